//--- hw/dsp_cfg.svh
`ifndef DSP_CFG_SVH
`define DSP_CFG_SVH

// ---------------------------------------------------------------
// serial element register indices
// ---------------------------------------------------------------
`define REG_DATA 3'h0
`define REG_IER 3'h1
`define REG_IIR 3'h2
`define REG_LCR 3'h3
`define REG_MCR 3'h4
`define REG_LSR 3'h5
`define REG_MSR 3'h6
`define REG_SCR 3'h7

// ---------------------------------------------------------------
// serial element field positions
// ---------------------------------------------------------------
`define LCR_DLAB_BIT 7
`define MCR_DTR_BIT 0
`define MCR_RTS_BIT 1
`define MCR_LOOP_BIT 4
`define MSR_DCD_BIT 3
`define MSR_CTS_BIT 4
`define MSR_DSR_BIT 5
`define MSR_RI_BIT 6
`define LSR_DR_BIT 0
`define LSR_OE_BIT 1
`define LSR_FE_BIT 3
`define LSR_THRE_BIT 5
`define LSR_TEMT_BIT 6

// ---------------------------------------------------------------
// reset values and fixed answers
// ---------------------------------------------------------------
`define BYTE_RST 8'h00
`define DIV_RST 16'h0000
`define DIV_ONE 16'h0001
`define IIR_NONE 8'h01
`define MARK_LEVEL 1'b1
`define SPACE_LEVEL 1'b0
`define LAST_BIT 3'h7
`define FIRST_BIT 3'h0
`define BUF_FULL_COUNT 2'h2
`define BUF_EMPTY_COUNT 2'h0
`define BUF_ONE_COUNT 2'h1

// ---------------------------------------------------------------
// parallel port
// ---------------------------------------------------------------
`define PP_REG_DATA 3'h0
`define PP_REG_STATUS 3'h1
`define PP_REG_CTRL 3'h2
`define PP_CTRL_DIR_BIT 5
`define PP_STATUS_RST 8'h00

`endif

//--- hw/dsp_pkg.sv
`include "dsp_cfg.svh"

package dsp_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
endpackage

//--- hw/pair_buffer.sv
`timescale 1ns/1ps
`include "dsp_cfg.svh"

module pair_buffer #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // filling side
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // draining side
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  if (WIDTH < 1) begin : g_chk
    $error("pair_buffer WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] mem_r [2];
  logic wr_ptr_r;
  logic rd_ptr_r;
  logic [1:0] count_r;
  logic push;
  logic pop;

  assign in_ready = (count_r != `BUF_FULL_COUNT);
  assign out_valid = (count_r != `BUF_EMPTY_COUNT);
  assign out_data = mem_r[rd_ptr_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_r <= ~wr_ptr_r;
      end
      if (pop) begin
        rd_ptr_r <= ~rd_ptr_r;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count_r <= `BUF_EMPTY_COUNT;
    end else if (push && !pop) begin
      count_r <= count_r + `BUF_ONE_COUNT;
    end else if (pop && !push) begin
      count_r <= count_r - `BUF_ONE_COUNT;
    end
  end
endmodule // pair_buffer

//--- hw/rx_framer.sv
`timescale 1ns/1ps
`include "dsp_cfg.svh"

module rx_framer #(
  parameter int DIV_W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // setup
  input wire logic enable,
  input wire logic [DIV_W-1:0] divisor,
  // serial line
  input wire logic line_in,
  // assembled byte
  output dsp_pkg::byte_t data_out,
  output logic data_valid,
  output logic frame_err
);
  import dsp_pkg::*;

  rx_state_t state_r;
  logic [DIV_W-1:0] cnt_r;
  logic [2:0] bit_r;
  byte_t shift_r;
  logic line_prev_r;
  logic tick;

  assign tick = (cnt_r == '0);
  assign data_out = shift_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      line_prev_r <= `MARK_LEVEL;
    end else begin
      line_prev_r <= line_in;
    end
  end

  // sampling at mid-bit; a glitch shorter than half a bit is rejected
  always_ff @(posedge clk) begin
    if (rst || !enable) begin
      state_r <= RX_IDLE;
      cnt_r <= '0;
      bit_r <= `FIRST_BIT;
    end else begin
      unique case (state_r)
        RX_IDLE: begin
          if (line_prev_r && !line_in) begin
            state_r <= RX_START;
            cnt_r <= divisor >> 1;
          end
        end
        RX_START: begin
          if (!tick) begin
            cnt_r <= cnt_r - 1'b1;
          end else if (line_in == `SPACE_LEVEL) begin
            state_r <= RX_DATA;
            cnt_r <= divisor - 1'b1;
            bit_r <= `FIRST_BIT;
          end else begin
            state_r <= RX_IDLE;
          end
        end
        RX_DATA: begin
          if (!tick) begin
            cnt_r <= cnt_r - 1'b1;
          end else begin
            cnt_r <= divisor - 1'b1;
            bit_r <= bit_r + 1'b1;
            if (bit_r == `LAST_BIT) begin
              state_r <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (!tick) begin
            cnt_r <= cnt_r - 1'b1;
          end else begin
            state_r <= RX_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      shift_r <= `BYTE_RST;
    end else if (state_r == RX_DATA && tick) begin
      shift_r <= {line_in, shift_r[7:1]};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      data_valid <= 1'b0;
      frame_err <= 1'b0;
    end else begin
      data_valid <= enable && state_r == RX_STOP && tick;
      frame_err <= enable && state_r == RX_STOP && tick && line_in == `SPACE_LEVEL;
    end
  end
endmodule // rx_framer

//--- hw/dual_serial_port_pin_interface.sv
`timescale 1ns/1ps
`include "dsp_cfg.svh"

// Overview of operation
// - with bidir enable low the parallel data lines are always driven
// - with bidir enable high the direction bit decides drive or input
// - modem status bit 5 shows the data-set-ready input
// - modem status bit 6 shows the ring indicator input
// - modem status bit 3 shows the carrier detect input
// - modem status bit 4 shows the clear-to-send input
// - terminal ready output follows modem control bit 0
// - request to send output follows modem control bit 1
// - reset puts both serial outputs at mark, logic one
// - loopback feeds own transmit line to receiver, ignoring the input pin
// - data bit 0 goes out first and is received first
// - host data bus driven only while returning read data
// - write strobe stores bus data in the addressed register of selected port
// - read strobe returns the addressed register of the selected port
// - reset forces idle, stopping all serial activity
// - after reset no serial activity until the host programs a divisor

module dual_serial_port_pin_interface #(
  parameter int DIV_W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // host bus
  input wire logic select_serial_zero,
  input wire logic select_serial_one,
  input wire logic select_printer_port,
  input wire logic [2:0] register_index_lines,
  input wire logic host_write_strobe,
  input wire logic host_read_strobe,
  input wire dsp_pkg::byte_t host_data_in,
  output dsp_pkg::byte_t host_data_out,
  output logic host_data_oe_n,
  // serial element zero
  input wire logic serial_rx_line_zero,
  output logic serial_tx_line_zero,
  input wire logic clear_to_send_zero,
  input wire logic data_set_ready_zero,
  input wire logic ring_indicator_zero,
  input wire logic carrier_detect_in_zero,
  output logic terminal_ready_zero,
  output logic request_to_send_zero,
  // serial element one
  input wire logic serial_rx_line_one,
  output logic serial_tx_line_one,
  input wire logic clear_to_send_one,
  input wire logic data_set_ready_one,
  input wire logic ring_indicator_one,
  input wire logic carrier_detect_in_one,
  output logic terminal_ready_one,
  output logic request_to_send_one,
  // parallel port
  input wire logic bidir_port_enable_in,
  input wire dsp_pkg::byte_t printer_data_in,
  output dsp_pkg::byte_t printer_data_out,
  output logic printer_data_oe_n
);
  import dsp_pkg::*;

  if (DIV_W < 9 || DIV_W > 16) begin : g_chk
    $error("DIV_W must be 9 to 16");
  end

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  function automatic logic hit(input logic sel, input logic strobe, input logic [2:0] idx,
                               input logic [2:0] want);
    hit = sel && strobe && (idx == want);
  endfunction

  logic [1:0] sel_ser;
  logic [1:0] rx_pin;
  logic [1:0] cts_in;
  logic [1:0] dsr_in;
  logic [1:0] ri_in;
  logic [1:0] dcd_in;
  logic [1:0] tx_pin;
  logic [1:0] dtr_out;
  logic [1:0] rts_out;
  byte_t ser_rdata [2];

  assign sel_ser = {select_serial_one, select_serial_zero};
  assign rx_pin = {serial_rx_line_one, serial_rx_line_zero};
  assign cts_in = {clear_to_send_one, clear_to_send_zero};
  assign dsr_in = {data_set_ready_one, data_set_ready_zero};
  assign ri_in = {ring_indicator_one, ring_indicator_zero};
  assign dcd_in = {carrier_detect_in_one, carrier_detect_in_zero};

  assign serial_tx_line_zero = tx_pin[0];
  assign serial_tx_line_one = tx_pin[1];
  assign terminal_ready_zero = dtr_out[0];
  assign terminal_ready_one = dtr_out[1];
  assign request_to_send_zero = rts_out[0];
  assign request_to_send_one = rts_out[1];

  // ---------------------------------------------------------------
  // serial elements
  // ---------------------------------------------------------------
  for (genvar g = 0; g < 2; g++) begin : g_ser
    byte_t lcr_r;
    byte_t ier_r;
    byte_t mcr_r;
    byte_t scr_r;
    logic [DIV_W-1:0] div_r;
    logic oe_flag_r;
    logic fe_flag_r;
    logic tx_pin_r;
    logic tx_bit_r;
    logic dtr_r;
    logic rts_r;
    tx_state_t tx_state_r;
    logic [DIV_W-1:0] tx_cnt_r;
    logic [2:0] tx_bitn_r;
    byte_t tx_shift_r;
    logic dlab;
    logic loop;
    logic enable;
    logic tx_tick;
    logic thr_push;
    logic tx_room;
    byte_t tx_head;
    logic tx_head_valid;
    logic tx_take;
    logic rx_line;
    byte_t rx_byte;
    logic rx_byte_valid;
    logic rx_frame_err;
    logic rx_room;
    byte_t rx_head;
    logic rx_head_valid;
    logic rx_pop;
    logic lsr_read;
    byte_t lsr;
    byte_t msr;
    logic wr_any;

    assign dlab = lcr_r[`LCR_DLAB_BIT];
    assign loop = mcr_r[`MCR_LOOP_BIT];
    assign enable = (div_r != '0);
    assign wr_any = host_write_strobe && sel_ser[g];
    assign thr_push = hit(sel_ser[g], host_write_strobe, register_index_lines, `REG_DATA)
                      && !dlab;
    assign rx_pop = hit(sel_ser[g], host_read_strobe, register_index_lines, `REG_DATA)
                    && !dlab;
    assign lsr_read = hit(sel_ser[g], host_read_strobe, register_index_lines, `REG_LSR);
    assign tx_tick = (tx_cnt_r == '0);
    assign tx_take = enable && tx_state_r == TX_IDLE;

    // a write while both entries hold data is dropped; software polls room first
    pair_buffer #(.WIDTH(8)) u_tx_buf (
      .clk(clk),
      .rst(rst),
      .in_data(host_data_in),
      .in_valid(thr_push),
      .in_ready(tx_room),
      .out_data(tx_head),
      .out_valid(tx_head_valid),
      .out_ready(tx_take)
    );

    assign rx_line = loop ? tx_bit_r : rx_pin[g];

    rx_framer #(.DIV_W(DIV_W)) u_rx (
      .clk(clk),
      .rst(rst),
      .enable(enable),
      .divisor(div_r),
      .line_in(rx_line),
      .data_out(rx_byte),
      .data_valid(rx_byte_valid),
      .frame_err(rx_frame_err)
    );

    pair_buffer #(.WIDTH(8)) u_rx_buf (
      .clk(clk),
      .rst(rst),
      .in_data(rx_byte),
      .in_valid(rx_byte_valid),
      .in_ready(rx_room),
      .out_data(rx_head),
      .out_valid(rx_head_valid),
      .out_ready(rx_pop)
    );

    // register writes
    always_ff @(posedge clk) begin
      if (rst) begin
        lcr_r <= `BYTE_RST;
        ier_r <= `BYTE_RST;
        mcr_r <= `BYTE_RST;
        scr_r <= `BYTE_RST;
        div_r <= '0;
      end else if (wr_any) begin
        unique case (register_index_lines)
          `REG_DATA: begin
            if (dlab) begin
              div_r[7:0] <= host_data_in;
            end
          end
          `REG_IER: begin
            if (dlab) begin
              div_r[DIV_W-1:8] <= host_data_in[DIV_W-9:0];
            end else begin
              ier_r <= host_data_in;
            end
          end
          `REG_LCR: lcr_r <= host_data_in;
          `REG_MCR: mcr_r <= host_data_in;
          `REG_SCR: scr_r <= host_data_in;
          default: begin
          end
        endcase
      end
    end

    // sticky line errors: a new error beats the clearing read
    always_ff @(posedge clk) begin
      if (rst) begin
        oe_flag_r <= 1'b0;
        fe_flag_r <= 1'b0;
      end else begin
        if (rx_byte_valid && !rx_room) begin
          oe_flag_r <= 1'b1;
        end else if (lsr_read) begin
          oe_flag_r <= 1'b0;
        end
        if (rx_frame_err) begin
          fe_flag_r <= 1'b1;
        end else if (lsr_read) begin
          fe_flag_r <= 1'b0;
        end
      end
    end

    // transmitter
    always_ff @(posedge clk) begin
      if (rst || !enable) begin
        tx_state_r <= TX_IDLE;
        tx_bit_r <= `MARK_LEVEL;
        tx_cnt_r <= '0;
        tx_bitn_r <= `FIRST_BIT;
        tx_shift_r <= `BYTE_RST;
      end else begin
        unique case (tx_state_r)
          TX_IDLE: begin
            if (tx_head_valid) begin
              tx_state_r <= TX_START;
              tx_bit_r <= `SPACE_LEVEL;
              tx_cnt_r <= div_r - `DIV_ONE;
              tx_shift_r <= tx_head;
            end
          end
          TX_START: begin
            if (!tx_tick) begin
              tx_cnt_r <= tx_cnt_r - 1'b1;
            end else begin
              tx_state_r <= TX_DATA;
              tx_bit_r <= tx_shift_r[0];
              tx_shift_r <= tx_shift_r >> 1;
              tx_bitn_r <= `FIRST_BIT;
              tx_cnt_r <= div_r - `DIV_ONE;
            end
          end
          TX_DATA: begin
            if (!tx_tick) begin
              tx_cnt_r <= tx_cnt_r - 1'b1;
            end else begin
              tx_cnt_r <= div_r - `DIV_ONE;
              if (tx_bitn_r == `LAST_BIT) begin
                tx_state_r <= TX_STOP;
                tx_bit_r <= `MARK_LEVEL;
              end else begin
                tx_bitn_r <= tx_bitn_r + 1'b1;
                tx_bit_r <= tx_shift_r[0];
                tx_shift_r <= tx_shift_r >> 1;
              end
            end
          end
          TX_STOP: begin
            if (!tx_tick) begin
              tx_cnt_r <= tx_cnt_r - 1'b1;
            end else begin
              tx_state_r <= TX_IDLE;
            end
          end
        endcase
      end
    end

    // pins: loopback holds the line at mark so the link sees nothing
    always_ff @(posedge clk) begin
      if (rst) begin
        tx_pin_r <= `MARK_LEVEL;
        dtr_r <= 1'b0;
        rts_r <= 1'b0;
      end else begin
        tx_pin_r <= loop ? `MARK_LEVEL : tx_bit_r;
        dtr_r <= mcr_r[`MCR_DTR_BIT];
        rts_r <= mcr_r[`MCR_RTS_BIT];
      end
    end

    always_comb begin
      msr = `BYTE_RST;
      msr[`MSR_DCD_BIT] = dcd_in[g];
      msr[`MSR_CTS_BIT] = cts_in[g];
      msr[`MSR_DSR_BIT] = dsr_in[g];
      msr[`MSR_RI_BIT] = ri_in[g];
    end

    always_comb begin
      lsr = `BYTE_RST;
      lsr[`LSR_DR_BIT] = rx_head_valid;
      lsr[`LSR_OE_BIT] = oe_flag_r;
      lsr[`LSR_FE_BIT] = fe_flag_r;
      lsr[`LSR_THRE_BIT] = tx_room;
      lsr[`LSR_TEMT_BIT] = !tx_head_valid && tx_state_r == TX_IDLE;
    end

    always_comb begin
      unique case (register_index_lines)
        `REG_DATA: ser_rdata[g] = dlab ? div_r[7:0] : rx_head;
        `REG_IER: ser_rdata[g] = dlab ? 8'(div_r[DIV_W-1:8]) : ier_r;
        `REG_IIR: ser_rdata[g] = `IIR_NONE;
        `REG_LCR: ser_rdata[g] = lcr_r;
        `REG_MCR: ser_rdata[g] = mcr_r;
        `REG_LSR: ser_rdata[g] = lsr;
        `REG_MSR: ser_rdata[g] = msr;
        `REG_SCR: ser_rdata[g] = scr_r;
      endcase
    end

    assign tx_pin[g] = tx_pin_r;
    assign dtr_out[g] = dtr_r;
    assign rts_out[g] = rts_r;
  end

  // ---------------------------------------------------------------
  // parallel port
  // ---------------------------------------------------------------
  byte_t pp_ctrl_r;
  byte_t pp_data_r;
  logic pp_oe_n_r;
  byte_t pp_rdata;
  logic pp_drive;

  // direction bit counts only while bidir enable is high
  assign pp_drive = !bidir_port_enable_in || !pp_ctrl_r[`PP_CTRL_DIR_BIT];

  always_ff @(posedge clk) begin
    if (rst) begin
      pp_data_r <= `BYTE_RST;
      pp_ctrl_r <= `BYTE_RST;
    end else begin
      if (hit(select_printer_port, host_write_strobe, register_index_lines, `PP_REG_DATA)) begin
        pp_data_r <= host_data_in;
      end
      if (hit(select_printer_port, host_write_strobe, register_index_lines, `PP_REG_CTRL)) begin
        pp_ctrl_r <= host_data_in;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pp_oe_n_r <= 1'b0;
    end else begin
      pp_oe_n_r <= !pp_drive;
    end
  end

  assign printer_data_out = pp_data_r;
  assign printer_data_oe_n = pp_oe_n_r;

  always_comb begin
    unique case (register_index_lines)
      `PP_REG_DATA: pp_rdata = pp_drive ? pp_data_r : printer_data_in;
      `PP_REG_STATUS: pp_rdata = `PP_STATUS_RST;
      `PP_REG_CTRL: pp_rdata = pp_ctrl_r;
      default: pp_rdata = `BYTE_RST;
    endcase
  end

  // ---------------------------------------------------------------
  // host read data
  // ---------------------------------------------------------------
  byte_t rdata_r;
  logic rd_oe_n_r;
  logic any_sel;

  assign any_sel = select_serial_zero || select_serial_one || select_printer_port;

  // read data registered, so the bus is driven only in the following cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_r <= `BYTE_RST;
      rd_oe_n_r <= 1'b1;
    end else begin
      rd_oe_n_r <= !(host_read_strobe && any_sel);
      if (host_read_strobe && select_serial_zero) begin
        rdata_r <= ser_rdata[0];
      end else if (host_read_strobe && select_serial_one) begin
        rdata_r <= ser_rdata[1];
      end else if (host_read_strobe && select_printer_port) begin
        rdata_r <= pp_rdata;
      end
    end
  end

  assign host_data_out = rdata_r;
  assign host_data_oe_n = rd_oe_n_r;
endmodule // dual_serial_port_pin_interface

//--- test/serial_port_checks_properties.sv
`timescale 1ns/1ps
`include "dsp_cfg.svh"

module serial_port_checks (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // host bus
  input wire logic select_serial_zero,
  input wire logic select_serial_one,
  input wire logic select_printer_port,
  input wire logic [2:0] register_index_lines,
  input wire logic host_write_strobe,
  input wire logic host_read_strobe,
  input wire dsp_pkg::byte_t host_data_in,
  input wire dsp_pkg::byte_t host_data_out,
  input wire logic host_data_oe_n,
  // modem side
  input wire logic serial_tx_line_zero,
  input wire logic serial_tx_line_one,
  input wire logic clear_to_send_zero,
  input wire logic data_set_ready_zero,
  input wire logic ring_indicator_zero,
  input wire logic carrier_detect_in_zero,
  input wire logic terminal_ready_zero,
  input wire logic request_to_send_one,
  // parallel port
  input wire logic bidir_port_enable_in,
  input wire logic printer_data_oe_n
);
  logic any_sel;
  logic programmed_r;
  assign any_sel = select_serial_zero | select_serial_one | select_printer_port;
  // ------
  // helper: lines may only move once the host wrote a serial element
  // ------
  always_ff @(posedge clk) begin
    if (rst) begin
      programmed_r <= 1'b0;
    end else if (host_write_strobe && (select_serial_zero || select_serial_one)) begin
      programmed_r <= 1'b1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_read_drives_bus: assert property (
    host_read_strobe && any_sel |=> !host_data_oe_n) else $error("read not driven");
  a_bus_released: assert property (
    !(host_read_strobe && any_sel) |=> host_data_oe_n) else $error("bus not released");
  a_dtr_follows: assert property (
    select_serial_zero && host_write_strobe && register_index_lines == `REG_MCR
    |-> ##2 terminal_ready_zero == $past(host_data_in[0], 2)) else $error("dtr wrong");
  a_rts_follows: assert property (
    select_serial_one && host_write_strobe && register_index_lines == `REG_MCR
    |-> ##2 request_to_send_one == $past(host_data_in[1], 2)) else $error("rts wrong");
  a_mark_on_reset: assert property (
    $past(rst) |-> serial_tx_line_zero && serial_tx_line_one) else $error("no mark");
  a_idle_until_set: assert property (
    !programmed_r |-> serial_tx_line_zero && serial_tx_line_one) else $error("early tx");
  a_status_bits: assert property (
    host_read_strobe && select_serial_zero && register_index_lines == `REG_MSR
    |=> host_data_out == {1'b0, $past(ring_indicator_zero), $past(data_set_ready_zero),
    $past(clear_to_send_zero), $past(carrier_detect_in_zero), 3'h0}) else $error("msr wrong");
  a_port_drives: assert property (
    !bidir_port_enable_in |=> !printer_data_oe_n) else $error("port not driven");
endmodule // serial_port_checks

//--- test/modem_model.sv
`timescale 1ns/1ps

module modem_model #(
  parameter int DIV = 4
) (
  // clock
  input wire logic clk,
  // serial lines
  input wire logic line_in,
  output logic line_out
);
  logic [7:0] got[$];
  initial line_out = 1'b1;
  // ------
  // sender, idles at mark
  // ------
  task automatic send_byte(input logic [7:0] b);
    @(posedge clk);
    line_out <= 1'b0;
    repeat (DIV) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      line_out <= b[i];
      repeat (DIV) @(posedge clk);
    end
    line_out <= 1'b1;
    repeat (DIV) @(posedge clk);
  endtask
  // mid-bit sampling keeps clear of edge-time races
  always begin : rx
    logic [7:0] v;
    @(negedge line_in);
    repeat (DIV / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (DIV) @(posedge clk);
      v[i] = line_in;
    end
    repeat (DIV) @(posedge clk);
    got.push_back(v);
  end
endmodule // modem_model

//--- test/testbench.sv
`timescale 1ns/1ps
`include "dsp_cfg.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED %0t got %0h exp %0h", $time, g, e); end end

module testbench;
  import dsp_pkg::*;
  localparam int DIV = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] sel = 3'h0;
  logic [2:0] idx = 3'h0;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic bidir = 1'b0;
  logic [3:0] ms0 = 4'h0;
  logic [3:0] ms1 = 4'h0;
  byte_t din = 8'h00;
  byte_t dout, pdout, d, par_in = 8'hC3;
  logic oe_n, poe_n, rx0, tx0, rx1, tx1, dtr0, rts0, dtr1, rts1;
  int fails = 0;
  int comparisons = 0;

  dual_serial_port_pin_interface #(.DIV_W(16)) dual_serial_port_pin_interface_inst (
    .clk(clk), .rst(rst), .select_serial_zero(sel[0]), .select_serial_one(sel[1]),
    .select_printer_port(sel[2]), .register_index_lines(idx), .host_write_strobe(wr_s),
    .host_read_strobe(rd_s), .host_data_in(din), .host_data_out(dout),
    .host_data_oe_n(oe_n), .serial_rx_line_zero(rx0), .serial_tx_line_zero(tx0),
    .clear_to_send_zero(ms0[1]), .data_set_ready_zero(ms0[2]),
    .ring_indicator_zero(ms0[3]), .carrier_detect_in_zero(ms0[0]),
    .terminal_ready_zero(dtr0), .request_to_send_zero(rts0),
    .serial_rx_line_one(rx1), .serial_tx_line_one(tx1), .clear_to_send_one(ms1[1]),
    .data_set_ready_one(ms1[2]), .ring_indicator_one(ms1[3]),
    .carrier_detect_in_one(ms1[0]), .terminal_ready_one(dtr1), .request_to_send_one(rts1),
    .bidir_port_enable_in(bidir), .printer_data_in(par_in), .printer_data_out(pdout),
    .printer_data_oe_n(poe_n));
  modem_model #(.DIV(DIV)) m0 (.clk(clk), .line_in(tx0), .line_out(rx0));
  modem_model #(.DIV(DIV)) m1 (.clk(clk), .line_in(tx1), .line_out(rx1));

  initial forever #50 clk = ~clk;
  // ------
  // bus tasks
  // ------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input int s, input logic [2:0] a, input byte_t v);
    @(posedge clk);
    sel <= 3'(1 << s);
    idx <= a;
    din <= v;
    wr_s <= 1'b1;
    @(posedge clk);
    sel <= 3'h0;
    wr_s <= 1'b0;
  endtask
  // s of 3 reads with no select, so the bus must stay released
  task automatic rd(input int s, input logic [2:0] a);
    @(posedge clk);
    sel <= 3'(1 << s);
    idx <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    sel <= 3'h0;
    rd_s <= 1'b0;
    @(posedge clk);
    d = dout;
    `CHK(oe_n, (s > 2));
  endtask
  task automatic setup(input int s);
    wr(s, `REG_LCR, 8'h80);
    wr(s, `REG_DATA, 8'(DIV));
    wr(s, `REG_IER, 8'h00);
    wr(s, `REG_LCR, 8'h03);
  endtask
  // ------
  // scenarios
  // ------
  task automatic t_scratch();
    wr(0, `REG_SCR, 8'h5A);
    wr(1, `REG_SCR, 8'hA5);
    rd(0, `REG_SCR);
    `CHK(d, 8'h5A);
    rd(1, `REG_SCR);
    `CHK(d, 8'hA5);
    rd(3, `REG_SCR);
  endtask
  task automatic t_status();
    for (int i = 0; i < 16; i++) begin
      ms0 <= 4'(i);
      ms1 <= ~4'(i);
      rd(0, `REG_MSR);
      `CHK(d, {1'b0, 4'(i), 3'h0});
      rd(1, `REG_MSR);
      `CHK(d, {1'b0, ~4'(i), 3'h0});
    end
  endtask
  task automatic t_control();
    for (int i = 0; i < 4; i++) begin
      wr(0, `REG_MCR, 8'(i));
      wr(1, `REG_MCR, 8'(i));
      cyc(2);
      `CHK({rts0, dtr0}, 2'(i));
      `CHK({rts1, dtr1}, 2'(i));
    end
  endtask
  task automatic t_parallel();
    wr(2, `PP_REG_CTRL, 8'h20);
    wr(2, `PP_REG_DATA, 8'h96);
    cyc(2);
    `CHK(poe_n, 1'b0);
    rd(2, `PP_REG_DATA);
    `CHK(d, 8'h96);
    bidir <= 1'b1;
    par_in <= 8'h3C;
    cyc(2);
    `CHK(poe_n, 1'b1);
    rd(2, `PP_REG_DATA);
    `CHK(d, 8'h3C);
    wr(2, `PP_REG_CTRL, 8'h00);
    cyc(2);
    `CHK(poe_n, 1'b0);
    `CHK(pdout, 8'h96);
  endtask
  // fourth byte overflows the two-entry buffer and must be dropped
  task automatic t_transmit();
    `CHK(tx0, 1'b1);
    setup(0);
    for (int i = 0; i < 4; i++) wr(0, `REG_DATA, 8'(8'hA5 + i));
    rd(0, `REG_LSR);
    `CHK(d[`LSR_THRE_BIT], 1'b0);
    for (int n = 0; n < 400 && m0.got.size() < 3; n++) cyc(1);
    cyc(60);
    `CHK(m0.got.size(), 3);
    for (int i = 0; i < 3; i++) `CHK(m0.got[i], 8'(8'hA5 + i));
  endtask
  task automatic t_receive();
    setup(1);
    m1.send_byte(8'h3C);
    m1.send_byte(8'h81);
    m1.send_byte(8'hE7);
    cyc(10);
    rd(1, `REG_LSR);
    `CHK(d[1:0], 2'b11);
    rd(1, `REG_DATA);
    `CHK(d, 8'h3C);
    rd(1, `REG_DATA);
    `CHK(d, 8'h81);
    rd(1, `REG_LSR);
    `CHK(d[0], 1'b0);
  endtask
  task automatic t_loopback();
    wr(0, `REG_MCR, 8'h10);
    fork
      m0.send_byte(8'h00);
      wr(0, `REG_DATA, 8'h5A);
    join
    for (int n = 0; n < 60; n++) begin
      cyc(1);
      `CHK(tx0, 1'b1);
    end
    rd(0, `REG_DATA);
    `CHK(d, 8'h5A);
  endtask
  // reset lands in mid-frame while the line is low
  task automatic t_reset();
    wr(0, `REG_MCR, 8'h00);
    wr(0, `REG_DATA, 8'h00);
    cyc(12);
    rst <= 1'b1;
    cyc(2);
    `CHK(tx0, 1'b1);
    rst <= 1'b0;
    cyc(80);
    `CHK(tx0, 1'b1);
  endtask
  task automatic end_sim();
    if (fails == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    cyc(20);
    rst <= 1'b0;
    t_scratch();
    t_status();
    t_control();
    t_parallel();
    t_transmit();
    t_receive();
    t_loopback();
    t_reset();
    end_sim();
  end
  initial begin
    cyc(20000);
    fails++;
    end_sim();
  end
endmodule // testbench

bind dual_serial_port_pin_interface serial_port_checks serial_port_checks_inst (
  .clk(clk), .rst(rst), .select_serial_zero(select_serial_zero),
  .select_serial_one(select_serial_one), .select_printer_port(select_printer_port),
  .register_index_lines(register_index_lines), .host_write_strobe(host_write_strobe),
  .host_read_strobe(host_read_strobe), .host_data_in(host_data_in),
  .host_data_out(host_data_out), .host_data_oe_n(host_data_oe_n),
  .serial_tx_line_zero(serial_tx_line_zero), .serial_tx_line_one(serial_tx_line_one),
  .clear_to_send_zero(clear_to_send_zero), .data_set_ready_zero(data_set_ready_zero),
  .ring_indicator_zero(ring_indicator_zero), .carrier_detect_in_zero(carrier_detect_in_zero),
  .terminal_ready_zero(terminal_ready_zero), .request_to_send_one(request_to_send_one),
  .bidir_port_enable_in(bidir_port_enable_in), .printer_data_oe_n(printer_data_oe_n));
